// File: hdl/remap_pkg.sv
package remap_pkg;
  // byte offsets of the remap register bank
  localparam logic [7:0] NP_CTRL_OFFSET      = 8'hE4;
  localparam logic [7:0] NP_UPPER_OFFSET     = 8'hE8;
  localparam logic [7:0] PF_CTRL_OFFSET      = 8'hEC;
  localparam logic [7:0] PF_UPPER_OFFSET     = 8'hF0;
  localparam logic [7:0] PRI_BASE_OFFSET     = 8'hF4;
  localparam logic [7:0] PRI_LIMIT_OFFSET    = 8'hF8;
  localparam logic [7:0] STATUS_OFFSET       = 8'hFC;

  // control register field positions
  localparam int LOWER_BASE_LSB = 20;
  localparam int LOWER_BASE_MSB = 31;
  localparam int IO_SIZE_LSB    = 8;
  localparam int IO_SIZE_MSB    = 12;
  localparam int ENABLE_BIT     = 3;

  // writable bits of each control register, the rest reads zero
  localparam logic [31:0] NP_CTRL_WMASK = 32'hFFF0_1F08;
  localparam logic [31:0] PF_CTRL_WMASK = 32'hFFF0_0008;
  localparam logic [31:0] FULL_WMASK    = 32'hFFFF_FFFF;

  // reset values
  localparam logic [11:0] LOWER_BASE_RESET = 12'h000;
  localparam logic [4:0]  IO_SIZE_RESET    = 5'h00;
  localparam logic        ENABLE_RESET     = 1'h0;
  localparam logic [31:0] UPPER_RESET      = 32'h0000_0000;

  // class of a downstream request
  typedef enum logic [1:0] {
    KIND_MEM_NP,
    KIND_MEM_PF,
    KIND_IO,
    KIND_OTHER
  } req_kind_type;
endpackage

// File: hdl/remap_win_if.sv
`timescale 1ns/100ps
`default_nettype none
// one remap window: settings and address in, hit and new address out
interface remap_win_if;
  logic        enable;
  logic        in_range;
  logic [31:0] upper_base;
  logic [11:0] lower_base;
  logic [63:0] in_addr;
  logic        hit;
  logic [63:0] out_addr;

  modport cfg (output enable, in_range, upper_base, lower_base, in_addr,
               input hit, out_addr);
  modport win (input enable, in_range, upper_base, lower_base, in_addr,
               output hit, out_addr);
endinterface
`default_nettype wire

// File: hdl/remap_window.sv
`timescale 1ns/100ps
`default_nettype none
module remap_window
  import remap_pkg::*;
(
  remap_win_if.win w
);
  // hit only while the window is switched on and the class matches
  always_comb begin
    w.hit      = w.enable && w.in_range;
    w.out_addr = w.in_addr;
    // upper base replaces 63:32, lower base 31:20, offset stays
    if (w.hit) begin
      w.out_addr = {w.upper_base, w.lower_base,
                    w.in_addr[LOWER_BASE_LSB-1:0]};
    end
  end
endmodule
`default_nettype wire

// File: hdl/downstream_address_remap_regs.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module downstream_address_remap_regs
  import remap_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  input  wire logic         req_valid_i,
  input  wire req_kind_type req_kind_i,
  input  wire logic [63:0]  req_addr_i,
  output logic              fwd_valid_o,
  output logic      [63:0]  fwd_addr_o,
  output logic              fwd_remapped_o
);
  typedef struct packed {
    logic [11:0] np_lower;
    logic        np_enable;
    logic [4:0]  io_size;
    logic [31:0] np_upper;
    logic [11:0] pf_lower;
    logic        pf_enable;
    logic [31:0] pf_upper;
    logic [31:0] pri_base;
    logic [31:0] pri_limit;
    logic        ack;
    logic [31:0] rdata;
    logic        fwd_valid;
    logic [63:0] fwd_addr;
    logic        fwd_remapped;
    logic [1:0]  last_hit;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  remap_win_if np_w ();
  remap_win_if pf_w ();

  logic        take;
  logic        wr;
  logic [31:0] np_ctrl;
  logic [31:0] pf_ctrl;
  logic [31:0] rd_mux;
  logic [31:0] io_mask;
  logic        pri_hit;
  logic [31:0] np_wr_v;
  logic [31:0] pf_wr_v;

  // byte lanes not selected keep the old value; reserved bits stay zero
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel,
                                        input logic [31:0] wmask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res & wmask;
  endfunction

  // a request is taken once; ack drops in the cycle after it rose
  assign take = cyc_i && stb_i && !s_r.ack;
  assign wr   = take && we_i;

  // control words as software sees them
  always_comb begin
    np_ctrl = 32'h0000_0000;
    np_ctrl[LOWER_BASE_MSB:LOWER_BASE_LSB] = s_r.np_lower;
    np_ctrl[IO_SIZE_MSB:IO_SIZE_LSB]       = s_r.io_size;
    np_ctrl[ENABLE_BIT]                    = s_r.np_enable;
    pf_ctrl = 32'h0000_0000;
    pf_ctrl[LOWER_BASE_MSB:LOWER_BASE_LSB] = s_r.pf_lower;
    pf_ctrl[ENABLE_BIT]                    = s_r.pf_enable;
  end

  // merged write words, built outside the next-state process
  assign np_wr_v = merge(np_ctrl, dat_i, sel_i, NP_CTRL_WMASK);
  assign pf_wr_v = merge(pf_ctrl, dat_i, sel_i, PF_CTRL_WMASK);

  // read decode; unmapped offsets answer with zero
  always_comb begin
    case (adr_i)
      NP_CTRL_OFFSET:   rd_mux = np_ctrl;
      NP_UPPER_OFFSET:  rd_mux = s_r.np_upper;
      PF_CTRL_OFFSET:   rd_mux = pf_ctrl;
      PF_UPPER_OFFSET:  rd_mux = s_r.pf_upper;
      PRI_BASE_OFFSET:  rd_mux = s_r.pri_base;
      PRI_LIMIT_OFFSET: rd_mux = s_r.pri_limit;
      STATUS_OFFSET:    rd_mux = {30'h0000_0000, s_r.last_hit};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // non-prefetchable window only hits inside the primary upper range
  assign pri_hit = (req_addr_i[63:32] >= s_r.pri_base) &&
                   (req_addr_i[63:32] <= s_r.pri_limit);

  // window settings into the two translators
  always_comb begin
    np_w.enable     = s_r.np_enable;
    np_w.in_range   = (req_kind_i == KIND_MEM_NP) && pri_hit;
    np_w.upper_base = s_r.np_upper;
    np_w.lower_base = s_r.np_lower;
    np_w.in_addr    = req_addr_i;
    pf_w.enable     = s_r.pf_enable;
    pf_w.in_range   = (req_kind_i == KIND_MEM_PF);
    pf_w.upper_base = s_r.pf_upper;
    pf_w.lower_base = s_r.pf_lower;
    pf_w.in_addr    = req_addr_i;
  end

  remap_window np_win (
    .w (np_w.win)
  );

  remap_window pf_win (
    .w (pf_w.win)
  );

  // keep only the low address bits an I/O transfer may carry
  assign io_mask = FULL_WMASK >> s_r.io_size;

  // next state: bus writes, read capture and the forwarded address
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ack   = take;
    s_nxt.rdata = take ? rd_mux : 32'h0000_0000;
    if (wr) begin
      case (adr_i)
        NP_CTRL_OFFSET: begin
          s_nxt.np_lower  = np_wr_v[LOWER_BASE_MSB:LOWER_BASE_LSB];
          s_nxt.io_size   = np_wr_v[IO_SIZE_MSB:IO_SIZE_LSB];
          s_nxt.np_enable = np_wr_v[ENABLE_BIT];
        end
        NP_UPPER_OFFSET:
          s_nxt.np_upper = merge(s_r.np_upper, dat_i, sel_i, FULL_WMASK);
        PF_CTRL_OFFSET: begin
          s_nxt.pf_lower  = pf_wr_v[LOWER_BASE_MSB:LOWER_BASE_LSB];
          s_nxt.pf_enable = pf_wr_v[ENABLE_BIT];
        end
        PF_UPPER_OFFSET:
          s_nxt.pf_upper = merge(s_r.pf_upper, dat_i, sel_i, FULL_WMASK);
        PRI_BASE_OFFSET:
          s_nxt.pri_base = merge(s_r.pri_base, dat_i, sel_i, FULL_WMASK);
        PRI_LIMIT_OFFSET:
          s_nxt.pri_limit = merge(s_r.pri_limit, dat_i, sel_i, FULL_WMASK);
        default: ;
      endcase
    end
    // one-cycle translation; settings written now apply next cycle
    s_nxt.fwd_valid    = req_valid_i;
    s_nxt.fwd_remapped = 1'b0;
    s_nxt.fwd_addr     = req_addr_i;
    if (req_valid_i) begin
      case (req_kind_i)
        KIND_MEM_NP: begin
          s_nxt.fwd_addr     = np_w.out_addr;
          s_nxt.fwd_remapped = np_w.hit;
        end
        KIND_MEM_PF: begin
          s_nxt.fwd_addr     = pf_w.out_addr;
          s_nxt.fwd_remapped = pf_w.hit;
        end
        KIND_IO:
          s_nxt.fwd_addr = {32'h0000_0000, req_addr_i[31:0] & io_mask};
        default: ;
      endcase
      s_nxt.last_hit = {pf_w.hit && req_kind_i == KIND_MEM_PF,
                        np_w.hit && req_kind_i == KIND_MEM_NP};
    end
  end

  // synchronous reset puts every field to its documented value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r           <= '0;
      s_r.np_lower  <= LOWER_BASE_RESET;
      s_r.io_size   <= IO_SIZE_RESET;
      s_r.np_enable <= ENABLE_RESET;
      s_r.np_upper  <= UPPER_RESET;
      s_r.pf_lower  <= LOWER_BASE_RESET;
      s_r.pf_enable <= ENABLE_RESET;
      s_r.pri_base  <= UPPER_RESET;
      s_r.pri_limit <= UPPER_RESET;
      s_r.pf_upper  <= UPPER_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign dat_o          = s_r.rdata;
  assign ack_o          = s_r.ack;
  assign fwd_valid_o    = s_r.fwd_valid;
  assign fwd_addr_o     = s_r.fwd_addr;
  assign fwd_remapped_o = s_r.fwd_remapped;

  // ack lasts exactly one cycle
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  np_lower_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == NP_CTRL_OFFSET && sel_i[3:2] == 2'b11)
      |=> s_r.np_lower == $past(dat_i[31:20]))
    else $error("non-prefetchable lower base not stored");

  io_size_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == NP_CTRL_OFFSET && sel_i[1])
      |=> s_r.io_size == $past(dat_i[IO_SIZE_MSB:IO_SIZE_LSB]))
    else $error("io size not stored");

  np_off_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_kind_i == KIND_MEM_NP && !s_r.np_enable)
      |=> !fwd_remapped_o && fwd_addr_o == $past(req_addr_i))
    else $error("non-prefetchable remap while disabled");

  np_upper_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == NP_UPPER_OFFSET && sel_i == 4'hF)
      |=> s_r.np_upper == $past(dat_i))
    else $error("non-prefetchable upper base not stored");

  pf_lower_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == PF_CTRL_OFFSET && sel_i[3:2] == 2'b11)
      |=> s_r.pf_lower == $past(dat_i[31:20]))
    else $error("prefetchable lower base not stored");

  pf_remap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_kind_i == KIND_MEM_PF)
      |=> fwd_remapped_o == $past(s_r.pf_enable))
    else $error("prefetchable enable not honoured");

  pri_range_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == PRI_BASE_OFFSET && sel_i == 4'hF)
      |=> s_r.pri_base == $past(dat_i) && $stable(s_r.pri_limit))
    else $error("primary upper base not stored");

  pri_limit_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == PRI_LIMIT_OFFSET && sel_i == 4'hF)
      |=> s_r.pri_limit == $past(dat_i))
    else $error("primary upper limit not stored");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !we_i && (adr_i == NP_CTRL_OFFSET || adr_i == PF_CTRL_OFFSET))
      |=> dat_o[19:13] == 7'h00 && dat_o[7:4] == 4'h0 && dat_o[2:0] == 3'h0
          && ($past(adr_i) != PF_CTRL_OFFSET || dat_o[12:8] == 5'h00))
    else $error("reserved control bits read nonzero");

  pf_upper_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == PF_UPPER_OFFSET && sel_i == 4'hF)
      |=> s_r.pf_upper == $past(dat_i))
    else $error("prefetchable upper base not stored");

  np_translate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_kind_i == KIND_MEM_NP && s_r.np_enable && pri_hit)
      |=> fwd_remapped_o
          && fwd_addr_o[63:32] == $past(s_r.np_upper)
          && fwd_addr_o[31:20] == $past(s_r.np_lower)
          && fwd_addr_o[19:0] == $past(req_addr_i[19:0]))
    else $error("non-prefetchable address not rewritten");

  pf_translate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_kind_i == KIND_MEM_PF && s_r.pf_enable)
      |=> fwd_remapped_o
          && fwd_addr_o[63:32] == $past(s_r.pf_upper)
          && fwd_addr_o[31:20] == $past(s_r.pf_lower)
          && fwd_addr_o[19:0] == $past(req_addr_i[19:0]))
    else $error("prefetchable address not rewritten");

  // shift pair drops the top bits without reusing the design's mask
  io_discard_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_valid_i && req_kind_i == KIND_IO)
      |=> !fwd_remapped_o && fwd_addr_o[63:32] == 32'h0000_0000
          && fwd_addr_o[31:0] == (($past(req_addr_i[31:0]) << $past(s_r.io_size))
                                  >> $past(s_r.io_size)))
    else $error("io address bits not discarded");

  // forwarded valid trails the request by exactly one cycle
  fwd_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fwd_valid_o == $past(req_valid_i))
    else $error("forwarded valid out of step");

  // every writable field back to zero one cycle after reset
  reset_clear_a: assert property (@(posedge clk_i)
    rst_i |=> np_ctrl == 32'h0000_0000 && pf_ctrl == 32'h0000_0000
              && s_r.np_upper == UPPER_RESET && s_r.pf_upper == UPPER_RESET
              && s_r.pri_base == UPPER_RESET && s_r.pri_limit == UPPER_RESET)
    else $error("registers not cleared by reset");
endmodule
`default_nettype wire

// File: verif/downstream_address_remap_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module downstream_address_remap_regs_tb_top
  import remap_pkg::*;
;
  logic         clk_i       = 1'b0;
  logic         rst_i       = 1'b1;
  logic         cyc_i       = 1'b0;
  logic         stb_i       = 1'b0;
  logic         we_i        = 1'b0;
  logic [7:0]   adr_i       = 8'h00;
  logic [3:0]   sel_i       = 4'h0;
  logic [31:0]  dat_i       = 32'h0000_0000;
  logic [31:0]  dat_o;
  logic         ack_o;
  logic         req_valid_i = 1'b0;
  req_kind_type req_kind_i  = KIND_OTHER;
  logic [63:0]  req_addr_i  = 64'h0;
  logic         fwd_valid_o;
  logic [63:0]  fwd_addr_o;
  logic         fwd_remapped_o;
  int           failures    = 0;
  int           checks      = 0;
  logic [31:0]  rd;

  downstream_address_remap_regs DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .req_addr_i(req_addr_i),
    .fwd_valid_o(fwd_valid_o), .fwd_addr_o(fwd_addr_o),
    .fwd_remapped_o(fwd_remapped_o)
  );

  // 50 MHz
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; held until ack is seen, data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      failures++;
      $display("Error bus ack expected 1 seen %b", ack_o);
      results();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, s, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hF, 32'h0000_0000, rd);
    check(name, {32'h0, rd}, {32'h0, exp});
  endtask

  // one request in, result seen one edge after it is taken
  task automatic xlate(input req_kind_type k, input logic [63:0] a,
                       input logic [63:0] exp, input logic rm);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_kind_i  <= k;
    req_addr_i  <= a;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
    check("fwd_valid", {63'h0, fwd_valid_o}, 64'h1);
    check("fwd_addr", fwd_addr_o, exp);
    check("fwd_remapped", {63'h0, fwd_remapped_o}, {63'h0, rm});
  endtask

  // every read-write register clears on reset
  task automatic t_reset;
    rd_chk("np_ctrl", NP_CTRL_OFFSET, 32'h0000_0000);
    rd_chk("np_upper", NP_UPPER_OFFSET, 32'h0000_0000);
    rd_chk("pf_ctrl", PF_CTRL_OFFSET, 32'h0000_0000);
    rd_chk("pf_upper", PF_UPPER_OFFSET, 32'h0000_0000);
    rd_chk("pri_base", PRI_BASE_OFFSET, 32'h0000_0000);
    rd_chk("pri_limit", PRI_LIMIT_OFFSET, 32'h0000_0000);
  endtask

  // all ones written; reserved control bits must stay zero
  task automatic t_ones;
    logic [7:0]  offs [6];
    logic [31:0] exps [6];
    offs = '{NP_CTRL_OFFSET, NP_UPPER_OFFSET, PF_CTRL_OFFSET,
             PF_UPPER_OFFSET, PRI_BASE_OFFSET, PRI_LIMIT_OFFSET};
    exps = '{32'hFFF0_1F08, 32'hFFFF_FFFF, 32'hFFF0_0008,
             32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], 4'hF, 32'hFFFF_FFFF);
      rd_chk("ones", offs[i], exps[i]);
    end
  endtask

  // single lanes leave the other bytes alone
  task automatic t_lanes;
    wr(NP_UPPER_OFFSET, 4'h2, 32'h0000_1200);
    rd_chk("np_upper_lane", NP_UPPER_OFFSET, 32'hFFFF_12FF);
    wr(NP_CTRL_OFFSET, 4'h8, 32'h0000_0000);
    rd_chk("np_ctrl_lane", NP_CTRL_OFFSET, 32'h00F0_1F08);
  endtask

  // holes answer zero and swallow writes
  task automatic t_unmapped;
    wr(8'hE0, 4'hF, 32'hFFFF_FFFF);
    rd_chk("hole_e0", 8'hE0, 32'h0000_0000);
    rd_chk("hole_00", 8'h00, 32'h0000_0000);
    wr(STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF);
    rd_chk("status_ro", STATUS_OFFSET, 32'h0000_0000);
  endtask

  // windows on, edges of the primary range, then np and pf both disabled
  task automatic t_xlate;
    wr(NP_CTRL_OFFSET, 4'hF, 32'h1230_0408);
    wr(NP_UPPER_OFFSET, 4'hF, 32'hAAAA_5555);
    wr(PF_CTRL_OFFSET, 4'hF, 32'hABC0_0008);
    wr(PF_UPPER_OFFSET, 4'hF, 32'h0F0F_0F0F);
    wr(PRI_BASE_OFFSET, 4'hF, 32'h0000_0010);
    wr(PRI_LIMIT_OFFSET, 4'hF, 32'h0000_0020);
    xlate(KIND_MEM_NP, 64'h0000_0010_FFF5_4321, 64'hAAAA_5555_1235_4321, 1'b1);
    rd_chk("status_np", STATUS_OFFSET, 32'h0000_0001);
    xlate(KIND_MEM_NP, 64'h0000_0020_0000_0001, 64'hAAAA_5555_1230_0001, 1'b1);
    xlate(KIND_MEM_NP, 64'h0000_0021_0000_0001, 64'h0000_0021_0000_0001, 1'b0);
    xlate(KIND_MEM_NP, 64'h0000_000F_0000_0001, 64'h0000_000F_0000_0001, 1'b0);
    xlate(KIND_MEM_PF, 64'h1234_5678_9ABC_DEF0, 64'h0F0F_0F0F_ABCC_DEF0, 1'b1);
    rd_chk("status_pf", STATUS_OFFSET, 32'h0000_0002);
    xlate(KIND_IO, 64'h0000_0000_F234_5678, 64'h0000_0000_0234_5678, 1'b0);
    xlate(KIND_OTHER, 64'h0000_0010_0000_0001, 64'h0000_0010_0000_0001, 1'b0);
    wr(NP_CTRL_OFFSET, 4'hF, 32'h1230_0400);
    wr(PF_CTRL_OFFSET, 4'hF, 32'hABC0_0000);
    xlate(KIND_MEM_NP, 64'h0000_0010_0000_0001, 64'h0000_0010_0000_0001, 1'b0);
    xlate(KIND_MEM_PF, 64'h1234_5678_9ABC_DEF0, 64'h1234_5678_9ABC_DEF0, 1'b0);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ones();
    t_lanes();
    t_unmapped();
    t_xlate();
    results();
  end
endmodule
`default_nettype wire
